/* File: core/pmm_cfg.svh */
// Purpose: constants for the program memory map and mode select block
// Assumes: 16-bit byte addresses, 8-bit data
// Notes:   vector, trap and reserved regions of the top page
`ifndef PMM_CFG_SVH
`define PMM_CFG_SVH
`define PMM_VEC_LO_START   16'h7F9C
`define PMM_VEC_LO_END     16'h7FBF
`define PMM_TRAP_START     16'h7FC0
`define PMM_TRAP_END       16'h7FDF
`define PMM_RSVD_START     16'h7FE0
`define PMM_RSVD_END       16'h7FEB
`define PMM_VEC_HI_START   16'h7FEC
`define PMM_VEC_HI_END     16'h7FFF
`define PMM_VEC_RESET      16'h7FFE
`define PMM_VEC_INT1       16'h7FFC
`define PMM_VEC_INT2       16'h7FFA
`define PMM_VEC_INT3       16'h7FF8
`define PMM_ROM_WAIT       2'h2
`define PMM_PROGRAM_VOLTAGE_SELECT_BIT_BIT       3'h6
`define PMM_ROM_BASE       16'h8000
`define PMM_ROM_AW         4'hF
`endif

/* File: core/pmm_core.sv */
// Purpose: program memory map, ROM read timing, EPROM write gate, mode select
// Assumes: single 50 MHz clock, all inputs synchronous
// Notes:   ROM contents come from an outside array via rom_rdata
`timescale 1ns/1ns
`default_nettype none
`include "pmm_cfg.svh"
// Operation
// - Vector regions reserved in top page
// - Sixteen trap vectors at 7FC0h-7FDFh
// - Reset and external interrupt vector slots
// - Mask ROM read takes two cycles
// - Secured parts block programmer readout
// - No on-chip memory: microprocessor only
// - EPROM reads ordinary, writes need sequence
// - EPROM write needs voltage and select bit
// - Programming voltage forces EEPROM override
// - Expansion parts: two groups, two variants
// - No expansion: single-chip only
// - Mode pin low at release: microcomputer
// - Mode pin high at release: microprocessor
// - Mode latched; new reset changes it
// - High voltage after reset: override
// - Control port pins pick three functions
// - Chip select and strobe function sets
// - Byte addressable, data and code fetch
module pmm_core (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // Straps and pins
  input  wire logic             mode_select_pin,
  input  wire logic             programming_voltage,
  input  wire logic             has_expansion,
  input  wire logic             has_onchip_prog,
  input  wire logic             secure_option,
  input  wire logic             ext_expand_en,
  // CPU fetch port
  input  wire logic             rd_req,
  input  wire logic             programmer_rd,
  input  wire logic [15:0]      rd_addr,
  // EPROM write request
  input  wire logic             eprom_wr_req,
  input  wire logic [7:0]       eprom_control_register,
  // Control port selects
  input  wire logic [15:0]      port_fn_sel,
  input  wire logic [7:0]       port_io_out,
  // ROM array
  input  wire logic [7:0]       rom_rdata,
  output logic [14:0]           rom_addr,
  // Read answer
  output logic                  rd_valid,
  output logic [7:0]            rd_data,
  output logic                  rd_ext,
  // Region flags
  output logic                  vec_region,
  output logic                  trap_region,
  output logic                  rsvd_region,
  // Vector address outputs
  output logic [15:0]           reset_vec_addr,
  output logic [15:0]           trap_vec_addr,
  // Mode and protection
  output logic [1:0]            mem_mode,
  output logic                  eprom_wr_en,
  output logic                  write_protect_override,
  output logic [7:0]            port_level
);
  logic       mp_mode;
  logic [7:0] pin_level;
  pmm_pkg::pmm_state_t st_reg;
  pmm_pkg::pmm_state_t st_next;
  logic [1:0]  wait_reg;
  logic [1:0]  wait_next;
  logic [15:0] addr_reg;
  logic [15:0] addr_next;
  logic        sec_reg;
  logic        sec_next;
  logic        onchip_hit;
  logic        rvalid_next;
  logic [7:0]  rdata_next;
  logic        rext_next;
  logic [14:0] raddr_next;
  logic        vec_next;
  logic        trap_next;
  logic        rsvd_next;
  logic [1:0]  mode_next;
  logic        wr_en_next;
  logic        wpo_next;
  logic        wpo_armed_reg;
  logic        wpo_armed_next;
  logic        cs_hit;
  logic        ext_hit;

  // Mode capture at reset release
  pmm_mode_latch u_mode (
    .sys_clk        (sys_clk),
    .nrst           (nrst),
    .mode_select_pin(mode_select_pin),
    .has_expansion  (has_expansion),
    .mp_mode        (mp_mode)
  );

  // Address falls in on-chip program space
  assign onchip_hit = has_onchip_prog && (rd_addr >= `PMM_ROM_BASE) &&
                      !mp_mode;
  // Chip select window and external access flag
  assign cs_hit  = rd_req && (rd_addr[15:13] == 3'h1) && ext_expand_en;
  assign ext_hit = rd_req && (mp_mode || ext_expand_en) && !has_onchip_prog;

  // Control port pin function slices
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      pmm_pin_fn u_fn (
        .fn_sel   (port_fn_sel[2*gi+1:2*gi]),
        .mp_mode  (mp_mode),
        .cs_hit   (cs_hit),
        .ext_hit  (ext_hit),
        .io_out   (port_io_out[gi]),
        .pin_level(pin_level[gi])
      );
    end
  endgenerate

  // ROM read sequencer: request, one wait, answer
  always_comb begin
    st_next     = st_reg;
    wait_next   = wait_reg;
    addr_next   = addr_reg;
    sec_next    = sec_reg;
    rvalid_next = 1'b0;
    rdata_next  = rd_data;
    rext_next   = 1'b0;
    raddr_next  = rom_addr;
    case (st_reg)
      pmm_pkg::PMM_ST_IDLE: begin
        if (rd_req && onchip_hit) begin
          addr_next  = rd_addr;
          raddr_next = rd_addr[14:0];
          sec_next   = programmer_rd & secure_option;
          wait_next  = `PMM_ROM_WAIT - 2'h1;
          st_next    = pmm_pkg::PMM_ST_WAIT;
        end else if (rd_req) begin
          rext_next = 1'b1;
        end
      end
      pmm_pkg::PMM_ST_WAIT: begin
        wait_next = wait_reg - 2'h1;
        if (wait_reg == 2'h1) begin
          st_next = pmm_pkg::PMM_ST_DONE;
        end
      end
      pmm_pkg::PMM_ST_DONE: begin
        rvalid_next = 1'b1;
        rdata_next  = sec_reg ? 8'h00 : rom_rdata;
        st_next     = pmm_pkg::PMM_ST_IDLE;
      end
      default: st_next = pmm_pkg::PMM_ST_IDLE;
    endcase
  end

  // Region flags decoded from rd_addr, then registered
  always_comb begin
    vec_next  = (rd_addr >= `PMM_VEC_LO_START && rd_addr <= `PMM_VEC_LO_END) ||
                (rd_addr >= `PMM_VEC_HI_START && rd_addr <= `PMM_VEC_HI_END);
    trap_next = rd_addr >= `PMM_TRAP_START && rd_addr <= `PMM_TRAP_END;
    rsvd_next = rd_addr >= `PMM_RSVD_START && rd_addr <= `PMM_RSVD_END;
  end

  // Mode, write gate and override; variant picks expansion or internal
  always_comb begin
    if (!has_expansion) begin
      mode_next = pmm_pkg::PMM_MODE_MC_SINGLE;
    end else if (mp_mode || !has_onchip_prog) begin
      mode_next = has_onchip_prog ? pmm_pkg::PMM_MODE_MP_INT
                                  : pmm_pkg::PMM_MODE_MP_NOINT;
    end else begin
      mode_next = ext_expand_en ? pmm_pkg::PMM_MODE_MC_EXPAND
                                : pmm_pkg::PMM_MODE_MC_SINGLE;
    end
    // Voltage ignored until after first post-reset cycle
    wpo_armed_next = 1'b1;
    wpo_next   = programming_voltage && wpo_armed_reg;
    wr_en_next = wpo_next && eprom_control_register[`PMM_PROGRAM_VOLTAGE_SELECT_BIT_BIT]
                 && eprom_wr_req && has_onchip_prog;
  end

  // Register all state and outputs
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg                 <= pmm_pkg::PMM_ST_IDLE;
      wait_reg               <= 2'h0;
      addr_reg               <= 16'h0000;
      sec_reg                <= 1'b0;
      rd_valid               <= 1'b0;
      rd_data                <= 8'h00;
      rd_ext                 <= 1'b0;
      rom_addr               <= 15'h0000;
      vec_region             <= 1'b0;
      trap_region            <= 1'b0;
      rsvd_region            <= 1'b0;
      mem_mode               <= 2'h0;
      eprom_wr_en            <= 1'b0;
      write_protect_override <= 1'b0;
      wpo_armed_reg          <= 1'b0;
      port_level             <= 8'hFF;
      reset_vec_addr         <= 16'h0000;
      trap_vec_addr          <= 16'h0000;
    end else begin
      st_reg                 <= st_next;
      wait_reg               <= wait_next;
      addr_reg               <= addr_next;
      sec_reg                <= sec_next;
      rd_valid               <= rvalid_next;
      rd_data                <= rdata_next;
      rd_ext                 <= rext_next;
      rom_addr               <= raddr_next;
      vec_region             <= vec_next;
      trap_region            <= trap_next;
      rsvd_region            <= rsvd_next;
      mem_mode               <= mode_next;
      eprom_wr_en            <= wr_en_next;
      write_protect_override <= wpo_next;
      wpo_armed_reg          <= wpo_armed_next;
      port_level             <= pin_level;
      // High byte at even address of each slot
      reset_vec_addr         <= `PMM_VEC_RESET;
      trap_vec_addr          <= `PMM_TRAP_END - {11'h000, rd_addr[3:0], 1'b1};
    end
  end
endmodule
`default_nettype wire

/* File: core/pmm_mode_latch.sv */
// Purpose: capture memory mode when reset is released
// Assumes: mode pin synchronous to sys_clk
// Notes:   capture occurs on first clock after reset deasserts
`timescale 1ns/1ns
`default_nettype none
module pmm_mode_latch (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // Straps
  input  wire logic             mode_select_pin,
  input  wire logic             has_expansion,
  // Result
  output var  logic             mp_mode
);
  logic armed_reg;
  logic armed_next;
  logic mp_next;

  // Catch the pin once, then hold until next reset
  always_comb begin
    armed_next = 1'b1;
    mp_next    = mp_mode;
    if (!armed_reg) begin
      mp_next = mode_select_pin & has_expansion;
    end
  end

  // No strap sampled under async reset: constants only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      armed_reg <= 1'b0;
      mp_mode   <= 1'b0;
    end else begin
      armed_reg <= armed_next;
      mp_mode   <= mp_next;
    end
  end
endmodule
`default_nettype wire

/* File: core/pmm_pin_fn.sv */
// Purpose: one control-port pin function select
// Assumes: software writes the select as plain ports
// Notes:   chip select only legal in microcomputer mode
`timescale 1ns/1ns
`default_nettype none
module pmm_pin_fn (
  // Inputs
  input  wire logic [1:0]       fn_sel,
  input  wire logic             mp_mode,
  input  wire logic             cs_hit,
  input  wire logic             ext_hit,
  input  wire logic             io_out,
  // Output level
  output logic                  pin_level
);
  // Active-low strobe and chip select, I/O passes through
  always_comb begin
    case (fn_sel)
      pmm_pkg::PMM_PIN_CS:  pin_level = ~(cs_hit & ~mp_mode);
      pmm_pkg::PMM_PIN_STB: pin_level = ~ext_hit;
      default:              pin_level = io_out;
    endcase
  end
endmodule
`default_nettype wire

/* File: core/pmm_pkg.sv */
// Purpose: types for the program memory map and mode select block
// Assumes: nothing beyond the cfg header
// Notes:   states are one-hot style codes; modes are binary
package pmm_pkg;
  typedef enum logic [1:0] {
    PMM_MODE_MC_SINGLE = 2'h0,
    PMM_MODE_MC_EXPAND = 2'h1,
    PMM_MODE_MP_NOINT  = 2'h2,
    PMM_MODE_MP_INT    = 2'h3
  } pmm_mode_t;
  typedef enum logic [2:0] {
    PMM_ST_IDLE = 3'h1,
    PMM_ST_WAIT = 3'h2,
    PMM_ST_DONE = 3'h4
  } pmm_state_t;
  typedef enum logic [1:0] {
    PMM_PIN_IO  = 2'h0,
    PMM_PIN_CS  = 2'h1,
    PMM_PIN_STB = 2'h2
  } pmm_pinfn_t;
endpackage

/* File: tb/pmm_core_chk.sv */
// Purpose: port checks for pmm_core
// Assumes: on-chip page is 8000h and up
// Notes:   mode valid two edges after release
`timescale 1ns/1ns
`default_nettype none
module pmm_core_chk (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        nrst,
  // Inputs
  input wire logic        mode_select_pin,
  input wire logic        programming_voltage,
  input wire logic        has_expansion,
  input wire logic        has_onchip_prog,
  input wire logic        secure_option,
  input wire logic        rd_req,
  input wire logic        programmer_rd,
  input wire logic [15:0] rd_addr,
  input wire logic [7:0]  eprom_control_register,
  input wire logic [15:0] port_fn_sel,
  input wire logic [7:0]  port_io_out,
  // Outputs
  input wire logic        rd_valid,
  input wire logic [7:0]  rd_data,
  input wire logic        vec_region,
  input wire logic        trap_region,
  input wire logic        rsvd_region,
  input wire logic [1:0]  mem_mode,
  input wire logic        eprom_wr_en,
  input wire logic        write_protect_override,
  input wire logic [7:0]  port_level
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [1:0] up_reg, up_next;
  logic       pin_reg, pin_next, busy_reg, busy_next, take;
  logic [2:0] hit;
  // Region decode of the current address
  assign hit = {(rd_addr >= 16'h7F9C && rd_addr <= 16'h7FBF) ||
                (rd_addr >= 16'h7FEC && rd_addr <= 16'h7FFF),
                rd_addr >= 16'h7FC0 && rd_addr <= 16'h7FDF,
                rd_addr >= 16'h7FE0 && rd_addr <= 16'h7FEB};
  // A taken read keeps the unit busy until its answer
  assign take = rd_req && has_onchip_prog && !mem_mode[1] && rd_addr[15]
                && up_reg[1] && (!busy_reg || rd_valid);
  // Edge count since release, pin capture, busy
  always_comb begin
    up_next   = (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
    pin_next  = (up_reg == 2'h0) ? mode_select_pin : pin_reg;
    busy_next = take ? 1'b1 : (rd_valid ? 1'b0 : busy_reg);
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      up_reg   <= 2'h0;
      pin_reg  <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      up_reg   <= up_next;
      pin_reg  <= pin_next;
      busy_reg <= busy_next;
    end
  end
  sequence s_ans; ##1 !rd_valid [*2] ##1 rd_valid; endsequence
  property p_lat; take |-> s_ans; endproperty
  a_lat: assert property (p_lat)
    else $error("rom answer not on third edge");
  property p_pulse; rd_valid |=> !rd_valid; endproperty
  a_pulse: assert property (p_pulse)
    else $error("answer strobe longer than one cycle");
  property p_sec; take && secure_option && programmer_rd |-> ##3 rd_data == 8'h00; endproperty
  a_sec: assert property (p_sec)
    else $error("secured byte leaked to programmer");
  property p_wr;
    eprom_wr_en |-> $past(programming_voltage) && $past(eprom_control_register[6]);
  endproperty
  a_wr: assert property (p_wr)
    else $error("eprom write open without voltage and select");
  property p_wpo; up_reg[1] |-> write_protect_override == $past(programming_voltage); endproperty
  a_wpo: assert property (p_wpo)
    else $error("override does not follow voltage");
  property p_mode;
    up_reg[1] && has_expansion && has_onchip_prog |-> mem_mode[1] == pin_reg;
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode differs from pin at release");
  property p_single; up_reg[1] && !has_expansion |-> mem_mode == pmm_pkg::PMM_MODE_MC_SINGLE;
  endproperty
  a_single: assert property (p_single)
    else $error("part without expansion left single chip");
  property p_flags;
    up_reg != 2'h0 |-> {vec_region, trap_region, rsvd_region} == $past(hit);
  endproperty
  a_flags: assert property (p_flags)
    else $error("region flags wrong");
  property p_io;
    up_reg[1] && $past(port_fn_sel[1:0]) == pmm_pkg::PMM_PIN_IO
      |-> port_level[0] == $past(port_io_out[0]);
  endproperty
  a_io: assert property (p_io)
    else $error("io pin does not follow output");
endmodule
bind pmm_core pmm_core_chk pmm_core_chk_inst (.sys_clk, .nrst, .mode_select_pin,
  .programming_voltage, .has_expansion, .has_onchip_prog, .secure_option, .rd_req,
  .programmer_rd, .rd_addr, .eprom_control_register, .port_fn_sel, .port_io_out,
  .rd_valid, .rd_data, .vec_region, .trap_region, .rsvd_region, .mem_mode,
  .eprom_wr_en, .write_protect_override, .port_level);
`default_nettype wire

/* File: tb/pmm_rom_mdl.sv */
// Purpose: board-side program ROM array model
// Assumes: array answers within the same cycle
// Notes:   contents are an address hash
`timescale 1ns/1ns
`default_nettype none
module pmm_rom_mdl (
  // Array port
  input  wire logic [14:0] rom_addr,
  output logic      [7:0]  rom_rdata
);
  // Hash keeps neighbouring bytes distinct
  always_comb rom_rdata = rom_addr[7:0] ^ {1'b0, rom_addr[14:8]} ^ 8'h5A;
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: self-checking bench for pmm_core
// Assumes: on-chip ROM page is 8000h-FFFFh
// Notes:   reads below it answer as external
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        sys_clk, nrst, mode_select_pin, programming_voltage, has_expansion;
  logic        has_onchip_prog, secure_option, ext_expand_en, rd_req, programmer_rd;
  logic        eprom_wr_req, rd_valid, rd_ext, vec_region, trap_region, rsvd_region;
  logic        eprom_wr_en, write_protect_override;
  logic [15:0] rd_addr, port_fn_sel, reset_vec_addr, trap_vec_addr;
  logic [7:0]  eprom_control_register, port_io_out, rom_rdata, rd_data, port_level;
  logic [14:0] rom_addr;
  logic [1:0]  mem_mode;
  int          miscompares, n_compared;
  // Rows: address, vec/trap/rsvd flags, external; external rows check flags and rd_ext only
  logic [19:0] rows [13] = '{20'h7F9B1, 20'h7F9C9, 20'h7FBF9, 20'h7FC05, 20'h7FDF5,
    20'h7FE03, 20'h7FEB3, 20'h7FEC9, 20'h7FFE9, 20'h7FFF9, 20'hFFFF0, 20'h80000,
    20'h9ABC0};
  pmm_core pmm_core_inst (.sys_clk, .nrst, .mode_select_pin, .programming_voltage,
    .has_expansion, .has_onchip_prog, .secure_option, .ext_expand_en, .rd_req,
    .programmer_rd, .rd_addr, .eprom_wr_req, .eprom_control_register, .port_fn_sel,
    .port_io_out, .rom_rdata, .rom_addr, .rd_valid, .rd_data, .rd_ext, .vec_region,
    .trap_region, .rsvd_region, .reset_vec_addr, .trap_vec_addr, .mem_mode,
    .eprom_wr_en, .write_protect_override, .port_level);
  pmm_rom_mdl pmm_rom_mdl_inst (.rom_addr, .rom_rdata);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  function automatic logic [7:0] romv(logic [15:0] a);
    return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h5A;
  endfunction
  task automatic chkw(string n, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Voltage kept low across release, as the board must
  task automatic do_rst(logic pin);
    nrst = 1'b0;
    mode_select_pin = pin;
    programming_voltage = 1'b0;
    repeat (3) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask
  // Request held until answer; bounded wait
  task automatic rd(logic [15:0] a, logic [3:0] x, logic [7:0] d);
    int n;
    rd_addr = a;
    rd_req = 1'b1;
    n = 1;
    @(negedge sys_clk);
    chkw("region", x[3:1], {vec_region, trap_region, rsvd_region});
    while (rd_valid !== 1'b1 && rd_ext !== 1'b1 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    rd_req = 1'b0;
    if (n == 8) begin
      miscompares++;
      end_of_test();
    end
    chkw("rd_ext", x[0], rd_ext);
    if (!x[0]) begin
      chkw("latency", 3, n);
      chkw("rd_data", d, rd_data);
    end
    @(negedge sys_clk);
  endtask
  initial begin
    miscompares = 0;
    n_compared = 0;
    {nrst, rd_req, programmer_rd, eprom_wr_req, mode_select_pin} = 5'h00;
    {has_expansion, has_onchip_prog, secure_option, ext_expand_en} = 4'hF;
    {rd_addr, port_fn_sel, eprom_control_register, port_io_out} = 48'h0;
    programming_voltage = 1'b0;
    @(negedge sys_clk);
    do_rst(1'b0);
    chkw("mode", 1'b0, mem_mode[1]);
    chkw("reset_vec", 16'h7FFE, reset_vec_addr);
    foreach (rows[i]) rd(rows[i][19:4], rows[i][3:0], romv(rows[i][19:4]));
    chkw("trap_vec", 16'h7FC6, trap_vec_addr);
    programmer_rd = 1'b1;
    rd(16'h8001, 4'h0, 8'h00);
    programmer_rd = 1'b0;
    // Voltage without select bit opens override only
    {programming_voltage, eprom_wr_req} = 2'h3;
    repeat (2) @(negedge sys_clk);
    chkw("override", 1'b1, write_protect_override);
    chkw("wr_en", 1'b0, eprom_wr_en);
    eprom_control_register = 8'h40;
    repeat (2) @(negedge sys_clk);
    chkw("wr_en", 1'b1, eprom_wr_en);
    programming_voltage = 1'b0;
    repeat (2) @(negedge sys_clk);
    chkw("wpo_wr", 2'h0, {write_protect_override, eprom_wr_en});
    port_io_out = 8'hA5;
    repeat (2) @(negedge sys_clk);
    chkw("io_pins", 8'hA5, port_level);
    port_fn_sel = 16'h5555;
    repeat (2) @(negedge sys_clk);
    chkw("cs_idle", 8'hFF, port_level);
    mode_select_pin = 1'b1;
    repeat (2) @(negedge sys_clk);
    chkw("mode_kept", 1'b0, mem_mode[1]);
    do_rst(1'b1);
    chkw("mode", 1'b1, mem_mode[1]);
    rd(16'h8000, 4'h1, 8'h00);
    has_expansion = 1'b0;
    do_rst(1'b1);
    chkw("single", pmm_pkg::PMM_MODE_MC_SINGLE, mem_mode);
    {has_expansion, has_onchip_prog} = 2'h2;
    do_rst(1'b0);
    chkw("romless", 1'b1, mem_mode[1]);
    end_of_test();
  end
endmodule
`default_nettype wire
